// ### core/i2cs_pkg.sv
package i2cs_pkg;

  // ****************************************
  // Register field positions
  // ****************************************
  localparam int CR1_OVF = 6;
  localparam int CR1_EN = 5;
  localparam int CR1_CKP = 4;
  localparam int CR1_MODE_HI = 3;
  localparam int CR1_MODE_LO = 0;
  localparam int STAT_RW = 2;
  localparam int STAT_UA = 1;
  localparam int STAT_BF = 0;
  localparam int PFR2_PIF = 7;

  // ****************************************
  // Mode codes and address constants
  // ****************************************
  localparam logic [3:0] MODE_SLAVE7 = 4'h6;
  localparam logic [3:0] MODE_SLAVE10 = 4'h7;
  localparam logic [3:0] MODE_MASTER = 4'h8;
  localparam logic [4:0] TENBIT_PREFIX = 5'h1e;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam int RX_DEPTH = 2;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_RECV = 3'b001,
    S_ACK = 3'b010,
    S_HOLD = 3'b011,
    S_TX = 3'b100,
    S_TXACK = 3'b101
  } i2cs_state_t;

  // Open-drain pull-down requests for the two bus lines
  typedef struct packed {
    logic scl_low;
    logic sda_low;
  } i2cs_line_t;

  // Status bits as seen by software
  typedef struct packed {
    logic rw;
    logic ua;
    logic bf;
  } i2cs_stat_t;

endpackage : i2cs_pkg

// ### core/i2cs_sync.sv
`timescale 1ns/1ns
`default_nettype none

module i2cs_sync #(
  parameter int W = 1
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  import i2cs_pkg::*;

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } i2cs_sync_state_t;

  i2cs_sync_state_t s_reg;
  i2cs_sync_state_t s_next;

  // Two-stage synchroniser; the first stage feeds only the second
  always_comb begin
    s_next = s_reg;
    s_next.meta = i_async;
    s_next.sync = s_reg.meta;
  end

  // Idle bus level is high, so reset to ones
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      s_reg <= '1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_sync = s_reg.sync;

endmodule : i2cs_sync

`default_nettype wire

// ### core/i2cs_rx_fifo.sv
`timescale 1ns/1ns
`default_nettype none

module i2cs_rx_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_valid,
  input wire logic [W-1:0] i_data,
  output logic o_ready,
  output logic o_valid,
  output logic [W-1:0] o_data,
  input wire logic i_ready
);
  import i2cs_pkg::*;

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [CW-1:0] cnt;
    logic full;
    logic valid;
    logic [W-1:0] head;
  } i2cs_fifo_state_t;

  i2cs_fifo_state_t s_reg;
  i2cs_fifo_state_t s_next;

  // Push and pop with registered full, valid and head word
  always_comb begin
    logic push;
    logic pop;
    push = 1'b0;
    pop = 1'b0;
    s_next = s_reg;
    push = i_valid && !s_reg.full;
    pop = s_reg.valid && i_ready;
    if (push) begin
      s_next.mem[s_reg.wr] = i_data;
      s_next.wr = (s_reg.wr == AW'(DEPTH - 1)) ? '0 : s_reg.wr + 1'b1;
    end
    if (pop) begin
      s_next.rd = (s_reg.rd == AW'(DEPTH - 1)) ? '0 : s_reg.rd + 1'b1;
    end
    s_next.cnt = s_reg.cnt + CW'(push) - CW'(pop);
    s_next.full = (s_next.cnt == CW'(DEPTH));
    s_next.valid = (s_next.cnt != '0);
    s_next.head = s_next.mem[s_next.rd];
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_ready = !s_reg.full;
  assign o_valid = s_reg.valid;
  assign o_data = s_reg.head;

endmodule : i2cs_rx_fifo

`default_nettype wire

// ### core/i2cs_slave.sv
// Operation
// [R1] Port and lines active only while enabled
// [R2] Mode field picks 7-bit, 10-bit or master
// [R3] Software leaves pins as inputs beforehand
// [R4] Double-buffered receive, byte sets interrupt flag
// [R5] Byte before buffer read sets overflow
// [R6] Automatic acknowledge then buffer load
// [R7] No acknowledge if full or overflow set
// [R8] Full buffer: keep buffer, set both flags
// [R9] Overflow only: load buffer, no acknowledge
// [R10] Buffer read clears full; overflow by write
// [R11] Wait START, sample data on clock rise
// [R12] Compare address bits at eighth falling edge
// [R13] Load and full at 8th, flag at 9th
// [R14] 10-bit high byte pattern and register form
// [R15] 10-bit byte sets update flag, holds clock
// [R16] Software swaps address bytes in 10-bit
// [R17] Repeated START matches first byte only
// [R18] Match copies direction bit, loads address
// [R19] Software clears interrupt flag each byte
// [R20] Read match: acknowledge, hold until release
// [R21] Transmit changes data on falling edges
// [R22] Master ack latched at ninth rise
// [R23] Master waits while clock is stretched
// [R24] Reset disables port, abandons transfer
// [R25] Disable returns idle, releases both lines
`timescale 1ns/1ns
`default_nettype none

module i2cs_slave (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl_out,
  output logic o_scl_oe,
  output logic o_sda_out,
  output logic o_sda_oe,
  input wire logic [7:0] i_wdata,
  input wire logic i_ctrl_wr,
  input wire logic i_addr_wr,
  input wire logic i_buf_wr,
  input wire logic i_buf_rd,
  input wire logic i_pif_clr,
  output logic [7:0] o_ctrl_one,
  output i2cs_pkg::i2cs_stat_t o_status,
  output logic o_pif,
  output logic [7:0] o_buf_data,
  output logic [7:0] o_own_addr,
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  input wire logic i_rx_ready
);
  import i2cs_pkg::*;

  // ****************************************
  // Engine state
  // ****************************************
  typedef struct packed {
    i2cs_state_t st;
    logic [3:0] cnt;
    logic [7:0] sr;
    logic [7:0] buffer;
    logic [7:0] own;
    logic en;
    logic [3:0] mode;
    logic clock_release_bit, ovf, pif;
    i2cs_stat_t stat;
    i2cs_line_t line;
    logic is_addr, addr2, restart, m10, ack, upd, tx, pend;
    logic [7:0] push_data;
    logic scl_prev, sda_prev;
  } i2cs_core_t;

  localparam i2cs_core_t CORE_RESET = '{
    st: S_IDLE, cnt: 4'h0, sr: BYTE_RESET, buffer: BYTE_RESET,
    own: BYTE_RESET, en: 1'b0, mode: 4'h0, clock_release_bit: 1'b0, ovf: 1'b0,
    pif: 1'b0, stat: '0, line: '0, is_addr: 1'b0, addr2: 1'b0,
    restart: 1'b0, m10: 1'b0, ack: 1'b0, upd: 1'b0, tx: 1'b0,
    pend: 1'b0, push_data: BYTE_RESET, scl_prev: 1'b1, sda_prev: 1'b1
  };

  i2cs_core_t s_reg, s_next;
  logic scl_s, sda_s, fifo_ready;

  // ****************************************
  // Pin synchronisers and bus events
  // ****************************************
  i2cs_sync #(.W(2)) u_sync (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_async({i_scl, i_sda}),
    .o_sync({scl_s, sda_s})
  );

  logic scl_rise, scl_fall, start_cond, stop_cond;
  logic active, mode7, mode10, eighth_fall;
  logic hi_match, hit, restart_first, release_ok;

  // Edges of the synchronised lines
  assign scl_rise = scl_s && !s_reg.scl_prev;
  assign scl_fall = !scl_s && s_reg.scl_prev;
  assign start_cond = scl_s && s_reg.scl_prev && s_reg.sda_prev && !sda_s;
  assign stop_cond = scl_s && s_reg.scl_prev && !s_reg.sda_prev && sda_s;

  // Only the two slave modes run the engine
  assign mode7 = (s_reg.mode == MODE_SLAVE7);
  assign mode10 = (s_reg.mode == MODE_SLAVE10);
  assign active = s_reg.en && (mode7 || mode10); // [R1] [R2]

  // Address decision at the eighth falling edge
  assign eighth_fall = (s_reg.st == S_RECV) && scl_fall &&
    (s_reg.cnt == BYTE_BITS);
  assign hi_match = (s_reg.sr[7:1] == s_reg.own[7:1]); // [R12]
  assign restart_first = s_reg.restart && s_reg.m10 && !s_reg.addr2;
  always_comb begin
    hit = 1'b0;
    if (!s_reg.is_addr) begin
      hit = 1'b1;
    end else if (mode7) begin
      hit = hi_match;
    end else if (s_reg.addr2) begin
      hit = (s_reg.sr == s_reg.own);
    end else begin
      hit = hi_match && (s_reg.sr[7:3] == TENBIT_PREFIX) &&
        (!s_reg.sr[0] || restart_first); // [R14] [R17]
    end
  end

  // Stretch ends once the stream buffer has taken the byte and any waited-for software action has happened
  assign release_ok = !s_reg.pend &&
    (s_reg.upd ? !s_reg.stat.ua : (!s_reg.tx || s_reg.clock_release_bit));

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    s_next = s_reg;
    s_next.scl_prev = scl_s;
    s_next.sda_prev = sda_s;
    if (s_reg.pend && fifo_ready) begin
      s_next.pend = 1'b0;
    end

    // Software accesses; hardware sets further down win
    if (i_ctrl_wr) begin
      s_next.en = i_wdata[CR1_EN];
      s_next.clock_release_bit = i_wdata[CR1_CKP];
      s_next.mode = i_wdata[CR1_MODE_HI:CR1_MODE_LO];
      s_next.ovf = s_reg.ovf && i_wdata[CR1_OVF]; // [R10]
    end
    if (i_addr_wr) begin
      s_next.own = i_wdata;
      s_next.stat.ua = 1'b0; // [R15]
    end
    if (i_buf_rd) begin
      s_next.stat.bf = 1'b0; // [R10]
    end
    if (i_buf_wr) begin
      s_next.buffer = i_wdata;
      if (s_reg.st == S_HOLD && s_reg.tx) begin
        s_next.sr = i_wdata; // [R20]
      end
    end
    if (i_pif_clr) begin
      s_next.pif = 1'b0;
    end

    // Bus engine
    if (!active || stop_cond) begin
      s_next.st = S_IDLE; // [R25]
      s_next.line = '0;
      s_next.m10 = 1'b0;
    end else if (start_cond) begin
      s_next.st = S_RECV; // [R11]
      s_next.cnt = 4'h0;
      s_next.is_addr = 1'b1;
      s_next.addr2 = 1'b0;
      s_next.restart = (s_reg.st != S_IDLE);
      s_next.m10 = (s_reg.st != S_IDLE) && s_reg.m10;
      s_next.line = '0;
    end else begin
      case (s_reg.st)
        S_IDLE: begin
          s_next.line = '0;
        end
        S_RECV: begin
          if (scl_rise) begin
            s_next.sr = {s_reg.sr[6:0], sda_s}; // [R11]
            s_next.cnt = s_reg.cnt + 4'h1;
          end
          if (eighth_fall) begin
            s_next.cnt = 4'h0;
            if (hit) begin
              s_next.ack = !s_reg.stat.bf && !s_reg.ovf; // [R6] [R7]
              s_next.line.sda_low = !s_reg.stat.bf && !s_reg.ovf;
              if (s_reg.stat.bf) begin
                s_next.ovf = 1'b1; // [R5] [R8]
              end else begin
                s_next.buffer = s_reg.sr; // [R4] [R9] [R13]
                s_next.stat.bf = 1'b1;
                s_next.pend = 1'b1;
                s_next.push_data = s_reg.sr;
              end
              if (s_reg.is_addr) begin
                s_next.stat.rw = s_reg.sr[0]; // [R18]
              end
              s_next.upd = s_reg.is_addr && mode10 && !restart_first;
              s_next.tx = s_reg.is_addr && s_reg.sr[0] &&
                (mode7 || restart_first); // [R20]
              if (s_reg.is_addr && s_reg.addr2) begin
                s_next.m10 = 1'b1;
              end
              s_next.st = S_ACK;
            end else begin
              s_next.st = S_IDLE;
            end
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            s_next.line.sda_low = 1'b0;
            s_next.pif = 1'b1; // [R4] [R13]
            s_next.is_addr = s_reg.upd && !s_reg.addr2;
            s_next.addr2 = s_reg.upd && !s_reg.addr2;
            if (!s_reg.ack) begin
              s_next.st = S_IDLE;
            end else if (s_reg.upd) begin
              s_next.stat.ua = 1'b1; // [R15]
              s_next.line.scl_low = 1'b1;
              s_next.st = S_HOLD;
            end else if (s_reg.tx || s_reg.pend) begin
              s_next.clock_release_bit = s_reg.clock_release_bit && !s_reg.tx; // [R20]
              s_next.line.scl_low = 1'b1;
              s_next.st = S_HOLD;
            end else begin
              s_next.st = S_RECV;
            end
          end
        end
        S_HOLD: begin
          s_next.line.scl_low = 1'b1;
          if (release_ok) begin
            s_next.line.scl_low = 1'b0; // [R15] [R20]
            s_next.cnt = 4'h0;
            s_next.upd = 1'b0;
            if (s_reg.tx) begin
              s_next.line.sda_low = !s_reg.sr[7];
              s_next.st = S_TX;
            end else begin
              s_next.st = S_RECV;
            end
          end
        end
        S_TX: begin
          if (scl_fall) begin
            s_next.cnt = s_reg.cnt + 4'h1;
            if (s_reg.cnt == BYTE_BITS - 4'h1) begin
              s_next.line.sda_low = 1'b0;
              s_next.st = S_TXACK;
            end else begin
              s_next.sr = {s_reg.sr[6:0], 1'b0};
              s_next.line.sda_low = !s_reg.sr[6]; // [R21]
            end
          end
        end
        S_TXACK: begin
          if (scl_rise) begin
            s_next.ack = !sda_s; // [R22]
            if (sda_s) begin
              s_next.st = S_IDLE;
            end
          end else if (scl_fall && s_reg.ack) begin
            s_next.pif = 1'b1;
            s_next.clock_release_bit = 1'b0;
            s_next.line.scl_low = 1'b1; // [R22]
            s_next.st = S_HOLD;
          end
        end
        default: begin
          s_next.st = S_IDLE;
          s_next.line = '0;
        end
      endcase
    end
  end

  // State register; reset disables the port
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      s_reg <= CORE_RESET; // [R24]
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************
  // Received-byte stream buffer
  // ****************************************
  i2cs_rx_fifo #(.W(8), .DEPTH(RX_DEPTH)) u_rx_fifo (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_valid(s_reg.pend),
    .i_data(s_reg.push_data),
    .o_ready(fifo_ready),
    .o_valid(o_rx_valid),
    .o_data(o_rx_data),
    .i_ready(i_rx_ready)
  );

  // Outputs; the driven level of an open-drain line is always low
  assign o_scl_out = 1'b0;
  assign o_sda_out = 1'b0;
  assign o_scl_oe = s_reg.line.scl_low;
  assign o_sda_oe = s_reg.line.sda_low;
  assign o_ctrl_one = {1'b0, s_reg.ovf, s_reg.en, s_reg.clock_release_bit, s_reg.mode};
  assign o_status = s_reg.stat;
  assign o_pif = s_reg.pif;
  assign o_buf_data = s_reg.buffer;
  assign o_own_addr = s_reg.own;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);

  a_disable_release: assert property ( // [R25]
    !active |=> !o_scl_oe && !o_sda_oe && s_reg.st == S_IDLE)
    else $error("lines not released when disabled");
  a_load_sets_full: assert property ( // [R13]
    active && !stop_cond && !start_cond && eighth_fall && hit &&
    !s_reg.stat.bf && !i_buf_wr
    |=> s_reg.stat.bf && s_reg.buffer == $past(s_reg.sr))
    else $error("matched byte not loaded");
  a_no_ack_flag: assert property ( // [R7]
    active && !stop_cond && !start_cond && eighth_fall && hit &&
    (s_reg.stat.bf || s_reg.ovf) |=> !o_sda_oe)
    else $error("acknowledge given with flags set");
  a_full_overflow: assert property ( // [R8]
    active && !stop_cond && !start_cond && eighth_fall && hit &&
    s_reg.stat.bf && !i_buf_wr
    |=> s_reg.ovf && $stable(s_reg.buffer))
    else $error("overflow not flagged or buffer changed");
  a_flag_ninth_fall: assert property ( // [R13]
    active && !stop_cond && !start_cond && s_reg.st == S_ACK && scl_fall
    |=> o_pif)
    else $error("interrupt flag missing at ninth fall");
  a_update_stretch: assert property ( // [R15]
    s_reg.st == S_HOLD && s_reg.upd && s_reg.stat.ua && active
    |-> o_scl_oe ##1 (o_scl_oe || !active || stop_cond || start_cond))
    else $error("clock not held while address update pending");
  a_release_bit_hold: assert property ( // [R20]
    s_reg.st == S_HOLD && s_reg.tx && !s_reg.clock_release_bit |-> o_scl_oe)
    else $error("clock not held before release bit");
  a_master_nack_idle: assert property ( // [R22]
    active && !stop_cond && !start_cond && s_reg.st == S_TXACK &&
    scl_rise && sda_s |=> s_reg.st == S_IDLE && !o_sda_oe)
    else $error("not-acknowledge did not reset slave");
  a_overflow_sticky: assert property ( // [R10]
    s_reg.ovf && !i_ctrl_wr |=> s_reg.ovf)
    else $error("overflow flag cleared without write");
  a_sample_rise: assert property ( // [R11]
    active && !stop_cond && !start_cond && s_reg.st == S_RECV &&
    scl_rise |=> s_reg.sr[0] == $past(sda_s))
    else $error("data bit not sampled on clock rise");

endmodule : i2cs_slave

`default_nettype wire

// ### verification/i2cs_bus_master.sv
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// Behavioural I2C bus master
// ****************************************
module i2cs_bus_master #(
  parameter int HALF = 20
) (
  input wire logic i_core_clk,
  input wire logic i_scl_oe,
  input wire logic i_scl_out,
  input wire logic i_sda_oe,
  input wire logic i_sda_out,
  output logic o_scl,
  output logic o_sda
);
  logic m_scl = 1'b1;
  logic m_sda = 1'b1;
  int stalls = 0;

  // Wired-AND lines; a released line floats up to the pull-up
  assign o_scl = m_scl & ~(i_scl_oe & ~i_scl_out);
  assign o_sda = m_sda & ~(i_sda_oe & ~i_sda_out);

  // Moves just after a clock edge, like every other driver
  task automatic pause(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask : pause

  // Raise the clock and wait out any stretching, within a bound
  task automatic rise();
    int k;
    m_scl = 1'b1;
    k = 0;
    while (o_scl !== 1'b1 && k < 4000) begin
      pause(1);
      k++;
    end
    if (k == 4000) begin
      stalls++;
    end
    pause(HALF);
  endtask : rise

  // Data set in the low phase, sampled late in the high phase
  task automatic bit_xfer(input logic v, output logic s);
    pause(4);
    m_sda = v;
    pause(HALF);
    rise();
    s = o_sda;
    m_scl = 1'b0;
  endtask : bit_xfer

  // Plain or repeated start
  task automatic start();
    if (m_scl == 1'b0) begin
      pause(4);
      m_sda = 1'b1;
      pause(HALF);
      rise();
    end
    m_sda = 1'b0;
    pause(HALF);
    m_scl = 1'b0;
  endtask : start

  task automatic stop();
    pause(4);
    m_sda = 1'b0;
    pause(HALF);
    rise();
    m_sda = 1'b1;
    pause(HALF);
  endtask : stop

  // Byte out MSB first, then the device's acknowledge
  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(b[i], s);
    end
    bit_xfer(1'b1, s);
    ack = ~s;
    pause(6);
  endtask : send

  // Byte in MSB first, then our acknowledge or not
  task automatic recv(input logic ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, s);
      b[i] = s;
    end
    bit_xfer(~ack, s);
    pause(6);
  endtask : recv
endmodule : i2cs_bus_master

`default_nettype wire

// ### verification/i2cs_slave_test.sv
`timescale 1ns/1ns
`default_nettype none

module i2cs_slave_test;
  import i2cs_pkg::*;

  // ****************************************
  // Signals and instances
  // ****************************************
  localparam int K_CTRL = 0;
  localparam int K_ADDR = 1;
  localparam int K_WR = 2;
  localparam int K_RD = 3;
  localparam int K_PCLR = 4;
  logic i_core_clk;
  logic i_rst;
  logic scl, sda, scl_out, scl_oe, sda_out, sda_oe;
  logic [7:0] wdata;
  logic ctrl_wr, addr_wr, buf_wr, buf_rd, pif_clr, rx_ready;
  logic [7:0] ctrl_one, buf_data, own_addr, rx_data, got;
  i2cs_stat_t status;
  logic pif, rx_valid, ack;
  int errors;
  int num_checks;

  i2cs_slave dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_scl(scl),
    .i_sda(sda), .o_scl_out(scl_out), .o_scl_oe(scl_oe),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_wdata(wdata),
    .i_ctrl_wr(ctrl_wr), .i_addr_wr(addr_wr), .i_buf_wr(buf_wr),
    .i_buf_rd(buf_rd), .i_pif_clr(pif_clr), .o_ctrl_one(ctrl_one),
    .o_status(status), .o_pif(pif), .o_buf_data(buf_data),
    .o_own_addr(own_addr), .o_rx_valid(rx_valid), .o_rx_data(rx_data),
    .i_rx_ready(rx_ready));

  i2cs_bus_master mst (.i_core_clk(i_core_clk), .i_scl_oe(scl_oe),
    .i_scl_out(scl_out), .i_sda_oe(sda_oe), .i_sda_out(sda_out),
    .o_scl(scl), .o_sda(sda));

  // 100 MHz clock
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask : tick

  // One-cycle software strobe
  task automatic sw(input int kind, input logic [7:0] d);
    wdata = d;
    ctrl_wr = (kind == K_CTRL);
    addr_wr = (kind == K_ADDR);
    buf_wr = (kind == K_WR);
    buf_rd = (kind == K_RD);
    pif_clr = (kind == K_PCLR);
    tick(1);
    {ctrl_wr, addr_wr, buf_wr, buf_rd, pif_clr} = 5'h00;
    tick(1);
  endtask : sw

  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  task automatic check_byte(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : check_byte

  task automatic check_bit(input logic g, input logic e);
    check_byte({7'h00, g}, {7'h00, e});
  endtask : check_bit

  // Bounded wait for the device to stretch the clock
  task automatic wait_hold();
    int k;
    k = 0;
    while (scl_oe !== 1'b1 && k < 2000) begin
      tick(1);
      k++;
    end
    if (k == 2000) begin
      errors++;
      conclude();
    end
  endtask : wait_hold

  task automatic pop(input logic [7:0] e);
    check_bit(rx_valid, 1'b1);
    check_byte(rx_data, e);
    rx_ready = 1'b1;
    tick(1);
    rx_ready = 1'b0;
    tick(1);
  endtask : pop

  // A stretch that the master gave up on ends the run at once
  always @(posedge i_core_clk) begin
    if (mst.stalls != 0) begin
      errors++;
      conclude();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    errors = 0;
    num_checks = 0;
    wdata = 8'h00;
    {ctrl_wr, addr_wr, buf_wr, buf_rd, pif_clr, rx_ready} = 6'h00;
    i_rst = 1'b1;
    tick(4);
    i_rst = 1'b0;
    sw(K_CTRL, 8'h26);
    sw(K_ADDR, 8'ha0);
    check_byte(ctrl_one, 8'h26);
    // Write: address then data, stream consumer stalled
    mst.start();
    mst.send(8'ha0, ack);
    check_bit(ack, 1'b1);
    check_byte(buf_data, 8'ha0);
    check_byte({5'h00, status}, 8'h01);
    check_bit(pif, 1'b1);
    sw(K_RD, 8'h00);
    sw(K_PCLR, 8'h00);
    mst.send(8'h5c, ack);
    check_bit(ack, 1'b1);
    check_byte(buf_data, 8'h5c);
    pop(8'ha0);
    pop(8'h5c);
    check_bit(rx_valid, 1'b0);
    rx_ready = 1'b1;
    sw(K_PCLR, 8'h00);
    // Buffer still full: byte refused
    mst.send(8'h33, ack);
    check_bit(ack, 1'b0);
    check_byte(buf_data, 8'h5c);
    check_bit(ctrl_one[CR1_OVF], 1'b1);
    check_bit(pif, 1'b1);
    mst.stop();
    // Overflow only: loaded but not acknowledged
    sw(K_RD, 8'h00);
    sw(K_PCLR, 8'h00);
    mst.start();
    mst.send(8'ha0, ack);
    check_bit(ack, 1'b0);
    check_byte(buf_data, 8'ha0);
    check_bit(pif, 1'b1);
    mst.stop();
    sw(K_CTRL, 8'h26);
    sw(K_RD, 8'h00);
    sw(K_PCLR, 8'h00);
    check_byte(ctrl_one, 8'h26);
    check_byte({5'h00, status}, 8'h00);
    // Foreign address ignored
    mst.start();
    mst.send(8'h42, ack);
    check_bit(ack, 1'b0);
    check_bit(pif, 1'b0);
    mst.stop();
    // Read: two bytes, second not acknowledged by the master
    mst.start();
    mst.send(8'ha1, ack);
    check_bit(ack, 1'b1);
    wait_hold();
    check_byte({5'h00, status}, 8'h05);
    check_bit(ctrl_one[CR1_CKP], 1'b0);
    sw(K_RD, 8'h00);
    sw(K_PCLR, 8'h00);
    sw(K_WR, 8'h96);
    sw(K_CTRL, 8'h36);
    mst.recv(1'b1, got);
    check_byte(got, 8'h96);
    wait_hold();
    check_bit(pif, 1'b1);
    sw(K_PCLR, 8'h00);
    sw(K_WR, 8'h3c);
    sw(K_CTRL, 8'h36);
    mst.recv(1'b0, got);
    check_byte(got, 8'h3c);
    check_bit(scl_oe, 1'b0);
    check_bit(sda_oe, 1'b0);
    check_bit(pif, 1'b0);
    mst.stop();
    // Held clock dropped by disable, then by reset
    for (int m = 0; m < 2; m++) begin
      sw(K_CTRL, 8'h26);
      sw(K_ADDR, 8'ha0);
      sw(K_RD, 8'h00);
      mst.start();
      mst.send(8'ha1, ack);
      wait_hold();
      if (m == 0) begin
        sw(K_CTRL, 8'h06);
      end else begin
        i_rst = 1'b1;
        tick(2);
        i_rst = 1'b0;
      end
      check_bit(scl_oe, 1'b0);
      check_bit(sda_oe, 1'b0);
      check_byte(ctrl_one, (m == 0) ? 8'h06 : 8'h00);
      mst.stop();
    end
    // Disabled, and master mode: no response
    sw(K_ADDR, 8'ha0);
    for (int m = 0; m < 2; m++) begin
      sw(K_CTRL, (m == 0) ? 8'h06 : 8'h28);
      mst.start();
      mst.send(8'ha0, ack);
      check_bit(ack, 1'b0);
      mst.stop();
    end
    // Ten-bit address, then repeated start for a read
    sw(K_CTRL, 8'h27);
    sw(K_ADDR, 8'hf2);
    mst.start();
    mst.send(8'hf2, ack);
    check_bit(ack, 1'b1);
    wait_hold();
    check_byte({5'h00, status}, 8'h03);
    sw(K_ADDR, 8'h5a);
    check_bit(status.ua, 1'b0);
    check_byte(own_addr, 8'h5a);
    sw(K_RD, 8'h00);
    sw(K_PCLR, 8'h00);
    mst.send(8'h5a, ack);
    check_bit(ack, 1'b1);
    wait_hold();
    check_byte(buf_data, 8'h5a);
    check_bit(status.ua, 1'b1);
    sw(K_ADDR, 8'hf2);
    sw(K_RD, 8'h00);
    sw(K_PCLR, 8'h00);
    mst.start();
    mst.send(8'hf3, ack);
    check_bit(ack, 1'b1);
    wait_hold();
    check_byte({5'h00, status}, 8'h05);
    check_bit(pif, 1'b1);
    sw(K_RD, 8'h00);
    sw(K_WR, 8'h81);
    sw(K_CTRL, 8'h37);
    mst.recv(1'b0, got);
    check_byte(got, 8'h81);
    mst.stop();
    check_byte(8'(mst.stalls), 8'h00);
    conclude();
  end
endmodule : i2cs_slave_test

`default_nettype wire
